// ==== shared/dacs_pkg.sv ====
package dacs_pkg;

  // ****************************************
  // Register map (indices; byte address is 4x)
  // ****************************************
  localparam int LAYERS = 32;
  localparam int LAYER_W = 5;
  localparam int IDX_W = 6;
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_STAT = 6'h01;
  localparam logic [5:0] REG_LAYER_FIRST = 6'h20;
  localparam logic [5:0] REG_LAYER_HIGH = 6'h28;
  localparam logic [5:0] REG_LAYER_LAST = 6'h3F;
  localparam int STACK_SEL_BIT = 5;
  localparam int IDX_LSB = 2;
  localparam logic [1:0] STACK_ADDR_TOP = 2'h1;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_PRST_BIT = 1;
  localparam int STAT_RUN_BIT = 8;
  localparam int STAT_END_BIT = 9;
  localparam int WORD_ADDR_LSB = 9;
  localparam int WORD_END_BIT = 8;

  // ****************************************
  // Source codes and patterns
  // ****************************************
  localparam logic [3:0] SRC_INPUT_LIMIT = 4'h8;
  localparam logic [3:0] SRC_SUPPLY = 4'h8;
  localparam logic [3:0] SRC_REGULATOR = 4'h9;
  localparam logic [3:0] SRC_RSVD_A = 4'hA;
  localparam logic [3:0] SRC_SELFTEST = 4'hB;
  localparam logic [3:0] SRC_RSVD_C = 4'hC;
  localparam logic [15:0] PATTERN_A = 16'hAAAA;
  localparam logic [15:0] PATTERN_B = 16'h5555;
  localparam int DEFAULT_LAYERS = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic layer_end_flag;
    logic [3:0] converter_b_source_select;
    logic [3:0] converter_a_source_select;
  } dacs_layer_t;

  typedef struct packed {
    logic is_input;
    logic [2:0] input_idx;
    logic supply;
    logic internal_regulator_diag;
    logic self_test;
    logic reserved;
  } dacs_src_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } dacs_conv_t;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } dacs_seq_state_t;

  // Default contents of one layer
  function automatic dacs_layer_t dacs_layer_reset(input logic [4:0] n);
    dacs_layer_t l;
    l = '0;
    if (n < 5'(DEFAULT_LAYERS)) begin
      l.converter_b_source_select = {1'b0, n[2:0]};
      l.converter_a_source_select = {1'b0, n[2:0]};
    end
    return l;
  endfunction

endpackage

// ==== verilog/dacs_src_map.sv ====
`timescale 1ns/1ns
`default_nettype none
module dacs_src_map
  import dacs_pkg::*;
(
  // Source code of one converter
  input wire logic [3:0] code,
  // Decoded source
  output dacs_src_t src
);

  wire logic in_range = code < SRC_INPUT_LIMIT;
  wire logic rsvd = (code == SRC_RSVD_A) || (code == SRC_RSVD_C) ||
                    (code > SRC_RSVD_C);

  assign src.is_input = in_range;
  assign src.input_idx = in_range ? code[2:0] : 3'h0;
  assign src.supply = code == SRC_SUPPLY;
  assign src.internal_regulator_diag = code == SRC_REGULATOR;
  assign src.self_test = code == SRC_SELFTEST;
  assign src.reserved = rsvd;

endmodule
`default_nettype wire

// ==== verilog/dacs_seq_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module dacs_seq_top
  import dacs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter side
  input wire logic conv_valid,
  input wire dacs_conv_t conv_data,
  // Source selection for the converters
  output dacs_src_t sel_a,
  output dacs_src_t sel_b,
  output logic [4:0] layer_ptr,
  // Delivered results
  output logic res_valid,
  output dacs_conv_t res_data,
  output logic [4:0] res_layer
);

  // ****************************************
  // State
  // ****************************************
  dacs_layer_t stack_q [LAYERS];
  logic [4:0] ptr_q, ptr_d;
  dacs_seq_state_t state_q, state_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pslverr_q, pslverr_d;
  dacs_src_t sel_a_q, sel_b_q;
  logic res_valid_q;
  dacs_conv_t res_q, res_d;
  logic [4:0] res_layer_q;

  // ****************************************
  // APB decode
  // ****************************************
  wire logic [IDX_W-1:0] idx = paddr[IDX_LSB +: IDX_W];
  wire logic setup = psel && !penable;
  wire logic access = psel && penable && pready_q;
  wire logic wr_en = access && pwrite;
  wire logic hit_stack = idx[STACK_SEL_BIT];
  wire logic [4:0] widx = idx[4:0];
  wire logic hit_ctrl = idx == REG_CTRL;
  wire logic hit_stat = idx == REG_STAT;
  wire logic unmapped = !(hit_stack || hit_ctrl || hit_stat);
  wire logic wr_stack = wr_en && hit_stack;
  wire logic wr_ctrl = wr_en && hit_ctrl;

  // ****************************************
  // Control
  // ****************************************
  wire logic prst = wr_ctrl && pstrb[0] && pwdata[CTRL_PRST_BIT];
  wire logic en_write = wr_ctrl && pstrb[0];
  wire logic en_val = pwdata[CTRL_ENABLE_BIT];

  always_comb begin
    state_d = state_q;
    if (en_write) begin
      state_d = en_val ? SEQ_RUN : SEQ_IDLE;
    end
    case (state_q)
      SEQ_IDLE: ;
      SEQ_RUN: ;
      default: state_d = SEQ_IDLE;
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  wire dacs_layer_t cur = stack_q[ptr_q];
  wire logic running = state_q == SEQ_RUN;
  wire logic advance = running && conv_valid && !prst;
  wire logic at_end = cur.layer_end_flag;

  always_comb begin
    ptr_d = ptr_q;
    if (prst) begin
      ptr_d = 5'h00;
    end else if (advance) begin
      if (at_end) begin
        ptr_d = 5'h00;
      end else begin
        ptr_d = ptr_q + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ptr_q <= 5'h00;
      state_q <= SEQ_IDLE;
    end else begin
      ptr_q <= ptr_d;
      state_q <= state_d;
    end
  end

  // ****************************************
  // Layer storage
  // ****************************************
  function automatic dacs_layer_t layer_merge(input dacs_layer_t old,
                                              input logic [31:0] wd,
                                              input logic [3:0] strb);
    dacs_layer_t n;
    n = old;
    if (strb[0]) begin
      n.converter_b_source_select = wd[7:4];
      n.converter_a_source_select = wd[3:0];
    end
    if (strb[1]) begin
      n.layer_end_flag = wd[WORD_END_BIT];
    end
    return n;
  endfunction

  always_ff @(posedge mclk) begin
    for (int i = 0; i < LAYERS; i++) begin
      if (sys_rst || prst) begin
        stack_q[i] <= dacs_layer_reset(5'(i));
      end else if (wr_stack && widx == 5'(i)) begin
        stack_q[i] <= layer_merge(stack_q[i], pwdata, pstrb);
      end
    end
  end

  // ****************************************
  // Source decode
  // ****************************************
  dacs_src_t dec_a, dec_b;

  dacs_src_map u_map_a (
    .code(cur.converter_a_source_select),
    .src(dec_a)
  );

  dacs_src_map u_map_b (
    .code(cur.converter_b_source_select),
    .src(dec_b)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sel_a_q <= '0;
      sel_b_q <= '0;
    end else begin
      sel_a_q <= dec_a;
      sel_b_q <= dec_b;
    end
  end

  // ****************************************
  // Result path
  // ****************************************
  always_comb begin
    res_d = conv_data;
    if (dec_a.self_test) begin
      res_d.a = PATTERN_A;
    end
    if (dec_b.self_test) begin
      res_d.b = PATTERN_B;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      res_valid_q <= 1'b0;
      res_q <= '0;
      res_layer_q <= 5'h00;
    end else begin
      res_valid_q <= conv_valid;
      if (conv_valid) begin
        res_q <= res_d;
        res_layer_q <= ptr_q;
      end
    end
  end

  // ****************************************
  // APB read and answer
  // ****************************************
  wire dacs_layer_t rd_layer = stack_q[widx];
  wire logic [6:0] own_addr = {STACK_ADDR_TOP, widx};
  wire logic [31:0] rd_stack = {16'h0000, own_addr, rd_layer};
  wire logic [31:0] rd_ctrl = {31'h0, running};
  wire logic [31:0] rd_stat = {22'h0, at_end, running, 3'h0, ptr_q};

  always_comb begin
    prdata_d = 32'h0000_0000;
    if (hit_stack) begin
      prdata_d = rd_stack;
    end else if (hit_ctrl) begin
      prdata_d = rd_ctrl;
    end else if (hit_stat) begin
      prdata_d = rd_stat;
    end
    pslverr_d = unmapped;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : prdata_d;
        pslverr_q <= pslverr_d;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sel_a = sel_a_q;
  assign sel_b = sel_b_q;
  assign layer_ptr = ptr_q;
  assign res_valid = res_valid_q;
  assign res_data = res_q;
  assign res_layer = res_layer_q;

  // ****************************************
  // Assertions
  // ****************************************
  property p_step;
    @(posedge mclk) disable iff (sys_rst)
    advance && !at_end |=> ptr_q == $past(ptr_q) + 5'h01;
  endproperty
  a_step: assert property (p_step) else $error("pointer did not step");

  property p_wrap;
    @(posedge mclk) disable iff (sys_rst)
    advance && at_end |=> ptr_q == 5'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap after last");

  property p_hold;
    @(posedge mclk) disable iff (sys_rst)
    !conv_valid && !prst |=> $stable(ptr_q);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved idle");

  property p_cycle_back;
    @(posedge mclk) disable iff (sys_rst)
    advance && at_end ##1 advance |=> ptr_q == 5'h01 || ptr_q == 5'h00;
  endproperty
  a_cycle_back: assert property (p_cycle_back) else $error("no cycling");

  property p_self_a;
    @(posedge mclk) disable iff (sys_rst)
    conv_valid && dec_a.self_test |=> res_valid_q && res_q.a == 16'hAAAA;
  endproperty
  a_self_a: assert property (p_self_a) else $error("bad pattern A");

  property p_self_b;
    @(posedge mclk) disable iff (sys_rst)
    conv_valid && dec_b.self_test |=> res_q.b == 16'h5555;
  endproperty
  a_self_b: assert property (p_self_b) else $error("bad pattern B");

  property p_map_b;
    @(posedge mclk) disable iff (sys_rst)
    cur.converter_b_source_select < 4'h8 |=> sel_b_q.is_input &&
      sel_b_q.input_idx == $past(cur.converter_b_source_select[2:0]);
  endproperty
  a_map_b: assert property (p_map_b) else $error("B input map wrong");

  property p_map_a;
    @(posedge mclk) disable iff (sys_rst)
    cur.converter_a_source_select == 4'h9 |=>
      sel_a_q.internal_regulator_diag && !sel_a_q.is_input;
  endproperty
  a_map_a: assert property (p_map_a) else $error("A diag map wrong");

  property p_prst;
    @(posedge mclk) disable iff (sys_rst)
    prst |=> ptr_q == 5'h00 && stack_q[7] == 9'h077 && stack_q[20] == 9'h000;
  endproperty
  a_prst: assert property (p_prst) else $error("partial reset wrong");

  property p_after_rst;
    @(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> ptr_q == 5'h00 && stack_q[3] == 9'h033 &&
      stack_q[0] == 9'h000 && stack_q[31] == 9'h000;
  endproperty
  a_after_rst: assert property (p_after_rst) else $error("reset values");

  property p_readback;
    @(posedge mclk) disable iff (sys_rst)
    setup && !pwrite && hit_stack |=>
      pready_q && prdata_q[15:9] == {2'h1, $past(widx)};
  endproperty
  a_readback: assert property (p_readback) else $error("address bits");

  property p_unmapped;
    @(posedge mclk) disable iff (sys_rst)
    setup && unmapped |=> pready_q && pslverr_q;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slave error");

  property p_low_dflt;
    @(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> stack_q[1] == 9'h011 && stack_q[6] == 9'h066 &&
      stack_q[7] == 9'h077;
  endproperty
  a_low_dflt: assert property (p_low_dflt)
    else $error("low layer defaults");

  property p_high_clear;
    @(posedge mclk) disable iff (sys_rst)
    prst |=> stack_q[9] == 9'h000 && stack_q[16] == 9'h000 &&
      stack_q[31] == 9'h000;
  endproperty
  a_high_clear: assert property (p_high_clear)
    else $error("upper layers kept");

  property p_res_layer;
    @(posedge mclk) disable iff (sys_rst)
    conv_valid |=> res_valid_q &&
      res_layer_q == $past(ptr_q);
  endproperty
  a_res_layer: assert property (p_res_layer)
    else $error("result layer wrong");

  c_wrap: cover property (@(posedge mclk) disable iff (sys_rst)
    advance && at_end && ptr_q != 5'h00);
  c_self: cover property (@(posedge mclk) disable iff (sys_rst)
    conv_valid && dec_a.self_test);
  c_prst: cover property (@(posedge mclk) disable iff (sys_rst) prst);
  c_wr_high: cover property (@(posedge mclk) disable iff (sys_rst)
    wr_stack && widx == 5'h1F);

endmodule
`default_nettype wire

// ==== sim/dacs_conv_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dacs_conv_model
  import dacs_pkg::*;
(
  // Clock and request
  input wire logic mclk,
  input wire logic fire,
  input wire dacs_conv_t din,
  // Converter outputs
  output logic conv_valid,
  output dacs_conv_t conv_data
);
  // One result pulse; data scrambled between pulses
  always @(posedge mclk) begin
    conv_valid <= fire;
    conv_data <= fire ? din : ~din;
  end
endmodule
`default_nettype wire

// ==== sim/dacs_seq_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module dacs_seq_top_tb
  import dacs_pkg::*;
;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, conv_valid, res_valid;
  logic fire = 1'h0;
  dacs_conv_t din = '0;
  dacs_conv_t conv_data, res_data;
  dacs_src_t sel_a, sel_b;
  logic [4:0] layer_ptr, res_layer, eptr;
  logic [8:0] lay [32];
  logic [31:0] rd, w;
  logic er, en;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  integer seed = 32'hcb2d832e;

  always #5 mclk = ~mclk;

  dacs_seq_top #(.ADDR_W(8)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_valid(conv_valid), .conv_data(conv_data),
    .sel_a(sel_a), .sel_b(sel_b), .layer_ptr(layer_ptr),
    .res_valid(res_valid), .res_data(res_data), .res_layer(res_layer));

  dacs_conv_model conv_far (.mclk(mclk), .fire(fire), .din(din),
    .conv_valid(conv_valid), .conv_data(conv_data));

  // ****************************************
  // Checking and reporting
  // ****************************************
  task tally_and_finish;
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task chk_src(input dacs_src_t got, input logic [3:0] c);
    dacs_src_t e;
    e = '0;
    e.is_input = c < SRC_INPUT_LIMIT;
    e.input_idx = (c < SRC_INPUT_LIMIT) ? c[2:0] : 3'h0;
    e.supply = c == SRC_SUPPLY;
    e.internal_regulator_diag = c == SRC_REGULATOR;
    e.self_test = c == SRC_SELFTEST;
    e.reserved = c == SRC_RSVD_A || c >= SRC_RSVD_C;
    chk({23'h0, got}, {23'h0, e});
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish;
    end
  end

  // ****************************************
  // Bus and converter drivers
  // ****************************************
  task apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    pstrb <= 4'hF;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wl(input int i, input logic [31:0] wd);
    apb(1'h1, 6'(32 + i), {wd[31:16], 7'(32 + i), wd[8:0]});
    lay[i] = wd[8:0];
  endtask

  task dflt;
    for (int i = 0; i < 32; i++) begin
      lay[i] = (i < 8) ? {1'h0, 4'(i), 4'(i)} : 9'h0;
    end
    eptr = 5'h0;
  endtask

  task rd_all;
    for (int i = 0; i < 32; i++) begin
      apb(1'h0, 6'(32 + i), 32'h0);
      chk(rd, {16'h0, 7'(32 + i), lay[i]});
      chk(er, 1'h0);
    end
  endtask

  task conv;
    dacs_conv_t d;
    logic [8:0] l;
    d = 32'($random(seed));
    @(posedge mclk);
    fire <= 1'h1;
    din <= d;
    @(posedge mclk);
    fire <= 1'h0;
    @(posedge mclk);
    #1;
    l = lay[eptr];
    chk(res_valid, 1'h1);
    chk(res_layer, eptr);
    chk(res_data.a, l[3:0] == SRC_SELFTEST ? PATTERN_A : d.a);
    chk(res_data.b, l[7:4] == SRC_SELFTEST ? PATTERN_B : d.b);
    if (en) begin
      eptr = l[8] ? 5'h0 : eptr + 5'h1;
    end
    chk(layer_ptr, eptr);
    @(posedge mclk);
    #1;
    chk(res_valid, 1'h0);
    chk_src(sel_a, lay[eptr][3:0]);
    chk_src(sel_b, lay[eptr][7:4]);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'h0;
    en = 1'h0;
    dflt;
    rd_all;
    apb(1'h0, 6'h02, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
    apb(1'h1, 6'h01, 32'hFFFF);
    apb(1'h0, 6'h01, 32'h0);
    chk(rd, 32'h0);
    // Layers 0-15 sweep every code on both sides
    for (int i = 0; i < 32; i++) begin
      w = $random(seed);
      if (i < 16) begin
        w[8:0] = {i == 15, 4'(15 - i), 4'(i)};
      end
      wl(i, w);
    end
    rd_all;
    conv;
    apb(1'h1, 6'h00, 32'h1);
    en = 1'h1;
    repeat (20) conv;
    apb(1'h0, 6'h01, 32'h0);
    chk(rd, {22'h0, lay[eptr][8], 1'h1, 3'h0, eptr});
    wl(15, 32'h00F0);
    repeat (20) conv;
    apb(1'h1, 6'h00, 32'h3);
    dflt;
    #1;
    chk(layer_ptr, 5'h0);
    rd_all;
    repeat (3) conv;
    wl(9, $random(seed));
    @(posedge mclk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'h0;
    en = 1'h0;
    dflt;
    #1;
    chk(layer_ptr, 5'h0);
    rd_all;
    conv;
    tally_and_finish;
  end
endmodule
`default_nettype wire
